// ### hw/wospt_pkg.sv
// Package of constants and types for the wait one-shot PWM timer
package wospt_pkg;
  localparam int WOSPT_CW = 16;
  localparam logic [15:0] WOSPT_ZERO = 16'h0000;
  localparam logic [15:0] WOSPT_ONE = 16'h0001;
  localparam logic [15:0] WOSPT_MAX = 16'hFFFF;
  // Count source select codes
  localparam logic [2:0] WOSPT_SRC_DIV1 = 3'h0;
  localparam logic [2:0] WOSPT_SRC_DIV2 = 3'h1;
  localparam logic [2:0] WOSPT_SRC_DIV4 = 3'h2;
  localparam logic [2:0] WOSPT_SRC_DIV8 = 3'h3;
  localparam logic [2:0] WOSPT_SRC_DIV32 = 3'h4;
  localparam logic [2:0] WOSPT_SRC_EXT = 3'h5;
  localparam logic [2:0] WOSPT_SRC_FAST = 3'h6;
  // Trigger edge select codes
  localparam logic [1:0] WOSPT_TRG_OFF = 2'h0;
  localparam logic [1:0] WOSPT_TRG_RISE = 2'h1;
  localparam logic [1:0] WOSPT_TRG_FALL = 2'h2;
  localparam logic [1:0] WOSPT_TRG_BOTH = 2'h3;
  // Status flag positions
  localparam int WOSPT_FLG_A = 0;
  localparam int WOSPT_FLG_B = 1;
  localparam int WOSPT_FLG_C = 2;
  localparam int WOSPT_FLG_OVF = 3;
  localparam int WOSPT_NFLG = 4;
  localparam logic [3:0] WOSPT_FLG_NONE = 4'h0;
  localparam logic [4:0] WOSPT_PRE_ZERO = 5'h00;
  localparam int WOSPT_CAP_DLY = 2;

  typedef struct packed {
    logic [2:0] count_source_select;
    logic init_level_high;
    logic active_high;
    logic clear_select;
  } wospt_ctl1_t;

  typedef struct packed {
    logic [1:0] trigger_edge_select;
    logic count_stop_select;
  } wospt_ctl2_t;

  typedef struct packed {
    logic buffer_select_c;
    logic buffer_select_d;
  } wospt_mode_t;
endpackage : wospt_pkg

// ### hw/wospt_top.sv
// Wait one-shot PWM timer with combined interrupt request
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// RULE1: Count on divided clock, fast osc, external edge
// RULE2: Untriggered period is period_reg plus one
// RULE3: Inactive for wait_point plus one after start
// RULE4: Active width is change point minus wait
// RULE5: Stop select ends count at period match
// RULE6: No trigger or no stop: start at once
// RULE7: Trigger and stop enabled: start waits for edge
// RULE8: Trigger edge rising, falling or both
// RULE9: Start bit cleared stops, initial level, keep
// RULE10: Flags on A, B, C matches and overflow
// RULE11: Pin B waveform, pin A trigger, C D idle
// RULE12: A period, B change, C wait, D buffer
// RULE13: Software never sets change equal to wait
// RULE14: Control one write drives initial level
// RULE15: Request set on enabled flag
// RULE16: Request drops when no enabled flag remains
// RULE17: Request stays one with further sources
// RULE18: Flags cleared only by software write
// RULE19: Match clear beats counter write
// RULE20: Software stops count before source change
// RULE21: Capture copy one to two clocks later
// RULE22: Software avoids mode write at period match
module wospt_top
  import wospt_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Count sources
  input wire logic fast_osc_clock,
  input wire logic external_count_clock_pin,
  // Pins
  input wire logic trigger_pin,
  input wire logic capture_pin,
  output logic pin_b,
  output logic pin_b_oe,
  // Control
  input wire logic count_start_bit,
  input wire logic ctl1_write,
  input wire wospt_pkg::wospt_ctl1_t timer_control_one,
  input wire wospt_pkg::wospt_ctl2_t timer_control_two,
  input wire wospt_pkg::wospt_mode_t timer_mode_reg,
  input wire logic waveform_enable,
  // Compare registers
  input wire logic [CW-1:0] period_reg,
  input wire logic [CW-1:0] change_point_reg,
  input wire logic [CW-1:0] wait_point_reg,
  input wire logic [CW-1:0] next_change_buffer_reg,
  // Counter write
  input wire logic count_write,
  input wire logic [CW-1:0] count_write_data,
  // Status and interrupt
  input wire logic [3:0] timer_irq_enables,
  input wire logic [3:0] flag_clear,
  output logic [3:0] timer_status_flags,
  output logic irq_request_bit,
  output logic [CW-1:0] count_value,
  output logic [CW-1:0] capture_value,
  output logic running
);
  import wospt_pkg::*;

  // ========================================================
  // Count source
  logic [4:0] prescale;
  logic ext_d, fast_d, trg_d, start_d, cap_d1, cap_d2;
  logic [CW-1:0] change_eff;

  wire ext_rise = external_count_clock_pin & ~ext_d;
  wire fast_rise = fast_osc_clock & ~fast_d;
  wire [2:0] src_sel = timer_control_one.count_source_select;
  logic tick;
  always_comb begin
    unique case (src_sel) // see RULE1
      WOSPT_SRC_DIV1: tick = 1'b1;
      WOSPT_SRC_DIV2: tick = prescale[0];
      WOSPT_SRC_DIV4: tick = &prescale[1:0];
      WOSPT_SRC_DIV8: tick = &prescale[2:0];
      WOSPT_SRC_DIV32: tick = &prescale;
      WOSPT_SRC_EXT: tick = ext_rise;
      WOSPT_SRC_FAST: tick = fast_rise;
      default: tick = 1'b0;
    endcase
  end

  // ========================================================
  // Start and trigger
  wire [1:0] tes = timer_control_two.trigger_edge_select;
  wire stop_sel = timer_control_two.count_stop_select;
  wire trg_rise = trigger_pin & ~trg_d;
  wire trg_fall = ~trigger_pin & trg_d;
  wire trg_hit = (tes == WOSPT_TRG_RISE && trg_rise) ||
                 (tes == WOSPT_TRG_FALL && trg_fall) ||
                 (tes == WOSPT_TRG_BOTH && (trg_rise || trg_fall)); // see RULE8
  wire trg_mode = (tes != WOSPT_TRG_OFF) && stop_sel;
  wire start_edge = count_start_bit & ~start_d;
  wire go_now = start_edge && !trg_mode; // see RULE6
  wire go_trg = count_start_bit && trg_mode && trg_hit && !running; // see RULE7
  wire trg_restart = go_trg;

  // ========================================================
  // Compare
  wire m_a = running && tick && count_value == period_reg;
  wire m_b = running && tick && count_value == change_eff;
  wire m_c = running && tick && count_value == wait_point_reg;
  wire ovf = running && tick && count_value == WOSPT_MAX;
  wire clr_a = m_a && timer_control_one.clear_select;
  wire stop_a = m_a && stop_sel; // see RULE5
  wire run_on = running && count_start_bit && !stop_a;
  wire [3:0] hits = {ovf, m_c, m_b, m_a}; // see RULE10

  logic [CW-1:0] next_count;
  always_comb begin
    next_count = count_value;
    if (trg_restart)
      next_count = WOSPT_ZERO;
    else if (clr_a || (m_a && stop_sel && timer_control_one.clear_select))
      next_count = WOSPT_ZERO; // see RULE19
    else if (count_write)
      next_count = count_write_data;
    else if (running && tick && !stop_a)
      next_count = count_value + WOSPT_ONE; // see RULE2
  end

  // ========================================================
  // Waveform
  wire init_lvl = timer_control_one.init_level_high;
  wire act_lvl = timer_control_one.active_high;
  logic next_pin;
  always_comb begin
    next_pin = pin_b;
    if (ctl1_write || !count_start_bit || stop_a || trg_restart)
      next_pin = init_lvl; // see RULE9 RULE14
    else if (m_c)
      next_pin = act_lvl; // see RULE3
    else if (m_b || m_a)
      next_pin = ~act_lvl; // see RULE4
  end

  // Change point comes from the buffer when buffer_select_d is set, loaded at each period end and while stopped
  wire [CW-1:0] next_change = timer_mode_reg.buffer_select_d ?
                              next_change_buffer_reg : change_point_reg;

  // ========================================================
  // Interrupt request is registered from the next flags and the enables
  wire [3:0] next_flags = (timer_status_flags & ~flag_clear) | hits;
  wire next_irq = |(next_flags & timer_irq_enables); // see RULE15 RULE16 RULE17

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale <= WOSPT_PRE_ZERO;
      ext_d <= 1'b0;
      fast_d <= 1'b0;
      trg_d <= 1'b0;
      start_d <= 1'b0;
      cap_d1 <= 1'b0;
      cap_d2 <= 1'b0;
      running <= 1'b0;
      count_value <= WOSPT_ZERO;
      capture_value <= WOSPT_ZERO;
      change_eff <= WOSPT_ZERO;
      pin_b <= 1'b0;
      pin_b_oe <= 1'b0;
      timer_status_flags <= WOSPT_FLG_NONE;
      irq_request_bit <= 1'b0;
    end else begin
      prescale <= prescale + 5'h01;
      ext_d <= external_count_clock_pin;
      fast_d <= fast_osc_clock;
      trg_d <= trigger_pin;
      start_d <= count_start_bit;
      running <= go_now || go_trg || run_on;
      count_value <= next_count;
      if (m_a || !running)
        change_eff <= next_change; // see RULE12
      pin_b <= next_pin;
      pin_b_oe <= waveform_enable; // see RULE11
      timer_status_flags <= next_flags; // see RULE18
      irq_request_bit <= next_irq;
      // Edge is seen one clock after the pin rises and copied on the next,
      // so the copy stays within the one to two clock window
      cap_d1 <= capture_pin;
      cap_d2 <= cap_d1;
      if (cap_d1 & ~cap_d2)
        capture_value <= count_value; // see RULE21
    end
  end
endmodule : wospt_top

// ### bench/wospt_asserts.sv
// Concurrent checks on the wait one-shot PWM timer ports
`timescale 1ns/1ps
// ==========================================================
// Checker
module wospt_chk
  import wospt_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controls
  input wire logic count_start_bit,
  input wire logic ctl1_write,
  input wire logic count_write,
  input wire logic waveform_enable,
  input wire wospt_pkg::wospt_ctl1_t timer_control_one,
  input wire wospt_pkg::wospt_ctl2_t timer_control_two,
  input wire logic [CW-1:0] count_write_data,
  input wire logic [3:0] timer_irq_enables,
  input wire logic [3:0] flag_clear,
  // Observed outputs
  input wire logic pin_b,
  input wire logic pin_b_oe,
  input wire logic [3:0] timer_status_flags,
  input wire logic irq_request_bit,
  input wire logic [CW-1:0] count_value,
  input wire logic running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] fe = timer_status_flags & timer_irq_enables;
  wire [3:0] fk = timer_status_flags & ~flag_clear;
  wire il = timer_control_one.init_level_high;
  wire imm = timer_control_two.trigger_edge_select == WOSPT_TRG_OFF ||
    !timer_control_two.count_stop_select;
  property p_irq; $past(rst_n) |-> irq_request_bit ==
    |(timer_status_flags & $past(timer_irq_enables)); endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_flg; $past(rst_n) |-> ($past(fk) & ~timer_status_flags) == 4'h0; endproperty
  a_flg: assert property (p_flg) else $error("flag lost");
  property p_oe; $past(rst_n) |-> pin_b_oe == $past(waveform_enable); endproperty
  a_oe: assert property (p_oe) else $error("enable lag");
  property p_stp; !count_start_bit |=> !running; endproperty
  a_stp: assert property (p_stp) else $error("no stop");
  property p_kp; !running && !count_write && !count_start_bit |=>
    $stable(count_value); endproperty
  a_kp: assert property (p_kp) else $error("count moved");
  property p_wr; count_write && !running |=> count_value == $past(count_write_data); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_ini; ctl1_write && !running && waveform_enable |=> pin_b == $past(il); endproperty
  a_ini: assert property (p_ini) else $error("init level");
  property p_go; $rose(count_start_bit) && imm |=> running; endproperty
  a_go: assert property (p_go) else $error("no start");
endmodule : wospt_chk

bind wospt_top wospt_chk #(.CW(CW)) chk_u (.clk, .rst_n, .count_start_bit,
  .ctl1_write, .count_write, .waveform_enable, .timer_control_one,
  .timer_control_two, .count_write_data, .timer_irq_enables, .flag_clear,
  .pin_b, .pin_b_oe, .timer_status_flags, .irq_request_bit, .count_value,
  .running);

// ### bench/wospt_far.sv
// Trigger source and waveform load model
`timescale 1ns/1ps
// ==========================================================
// Far side
module wospt_far (
  // Clock
  input wire logic clk,
  // Command and pins
  input wire logic go,
  input wire logic pin_b,
  output logic trigger_pin,
  output int hi
);
  initial trigger_pin = 1'h0;
  initial hi = 0;
  // Level is held between commands, so each edge stands many cycles
  always @(posedge clk) begin
    if (go) begin
      trigger_pin <= ~trigger_pin;
      hi <= 0;
    end else if (pin_b) begin
      hi <= hi + 1;
    end
  end
endmodule : wospt_far

// ### bench/tb.sv
// Self-checking bench for the wait one-shot PWM timer
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb;
  import wospt_pkg::*;
  logic clk = 0, rst_n = 0, st = 0, c1w = 0, cw = 0, cap = 0, go = 0, we = 0;
  logic pb, oe, irq, run, trg;
  logic [3:0] ie = 4'hF, fc = 4'h0, fl;
  logic [15:0] m = 16'h0, n = 16'h1, p = 16'h0, wd = 16'h0, cv, capv;
  wospt_ctl1_t c1 = '0;
  wospt_ctl2_t c2 = '0;
  int hi, t, n_mismatch = 0, n_tests = 0;
  int dv [5] = '{1, 2, 4, 8, 32};
  int eo [3] = '{2, 1, 3};
  // Source, clear, wait, change, period; change never equals wait
  logic [51:0] rows [5] = '{{WOSPT_SRC_DIV1, 1'h1, 16'h1, 16'h3, 16'h5},
    {WOSPT_SRC_DIV2, 1'h0, 16'h0, 16'h2, 16'h4},
    {WOSPT_SRC_DIV4, 1'h1, 16'h2, 16'h6, 16'h7},
    {WOSPT_SRC_DIV8, 1'h0, 16'h1, 16'h2, 16'h3},
    {WOSPT_SRC_DIV32, 1'h1, 16'h0, 16'h1, 16'h2}};
  wospt_top #(.CW(16)) dut_u (.clk, .rst_n, .fast_osc_clock(1'h0),
    .external_count_clock_pin(1'h0), .trigger_pin(trg), .capture_pin(cap),
    .pin_b(pb), .pin_b_oe(oe), .count_start_bit(st), .ctl1_write(c1w),
    .timer_control_one(c1), .timer_control_two(c2), .timer_mode_reg(2'h0),
    .waveform_enable(we), .period_reg(m), .change_point_reg(n),
    .wait_point_reg(p), .next_change_buffer_reg(16'h0), .count_write(cw),
    .count_write_data(wd), .timer_irq_enables(ie), .flag_clear(fc),
    .timer_status_flags(fl), .irq_request_bit(irq), .count_value(cv),
    .capture_value(capv), .running(run));
  wospt_far far_u (.clk, .go, .pin_b(pb), .trigger_pin(trg), .hi);
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic drain;
    t = 0;
    while (run === 1'h1 && t < 4000) begin
      tick(1);
      t++;
    end
    tick(2);
  endtask : drain
  // Zero the counter and rewrite control one, optionally flipping trigger
  task automatic arm(input logic g);
    wd = 16'h0;
    {cw, c1w, go} = {2'h3, g};
    tick(1);
    {cw, c1w, go} = 3'h0;
  endtask : arm
  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial forever #25 clk = ~clk;
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    tick(10);
    {rst_n, we} = 2'h3;
    chk("reset", {fl, irq, run, cv, pb}, 32'h0);
    c1.active_high = 1'h1;
    c2.count_stop_select = 1'h1;
    for (int i = 0; i < 5; i++) begin
      {c1.count_source_select, c1.clear_select, p, n, m} = rows[i];
      arm(1'h1);
      st = 1'h1;
      tick(2);
      drain();
      chk("high width", hi, (n - p) * dv[i]);
      if (i == 0) chk("period", t + 1, m + 1);
      chk("count", cv, c1.clear_select ? 16'h0 : m);
      chk("flags", {irq, fl}, 5'h17);
      ie = 4'h0;
      tick(2);
      chk("masked", irq, 1'h0);
      ie = 4'hF;
      tick(2);
      chk("unmasked", irq, 1'h1);
      fc = 4'hF;
      tick(1);
      fc = 4'h0;
      tick(2);
      chk("cleared", {irq, fl}, 5'h00);
      st = 1'h0;
      tick(1);
      $display("row %0d done", i);
    end
    {c1.count_source_select, c1.clear_select} = {WOSPT_SRC_DIV1, 1'h1};
    {p, n, m} = {16'h1, 16'h3, 16'h9};
    for (int e = 0; e < 3; e++) begin
      c2.trigger_edge_select = eo[e][1:0];
      arm(1'h0);
      st = 1'h1;
      tick(4);
      chk("armed idle", run, 1'h0);
      go = 1'h1;
      tick(1);
      go = 1'h0;
      tick(5);
      chk("triggered", run, 1'h1);
      drain();
      st = 1'h0;
      tick(1);
      $display("trigger %0d done", e);
    end
    c2 = {WOSPT_TRG_OFF, 1'h1};
    {p, n, m} = {16'h1, 16'h80, 16'h100};
    arm(1'h0);
    st = 1'h1;
    tick(20);
    chk("active", pb, 1'h1);
    st = 1'h0;
    tick(2);
    chk("halted", {run, pb}, 2'h0);
    c1.init_level_high = 1'h1;
    c1w = 1'h1;
    tick(1);
    c1w = 1'h0;
    tick(1);
    chk("init level", pb, 1'h1);
    wd = 16'h1234;
    cw = 1'h1;
    tick(1);
    {cw, cap} = 2'h1;
    tick(5);
    cap = 1'h0;
    chk("capture", capv, 16'h1234);
    c2 = {WOSPT_TRG_OFF, 1'h0};
    arm(1'h0);
    st = 1'h1;
    tick(10);
    t = cv;
    cap = 1'h1;
    tick(4);
    {cap, st} = 2'h0;
    chk("capture delay", (capv - t) inside {1, 2}, 1'h1);
    $display("stop and capture done");
    summarize();
  end
endmodule : tb
